// ===== inc/ohmux_params.svh
// constants for the overhead control signal multiplexer
// Behaviour
// RL1: connect and ready tripled into adjacent overhead bits
// RL2: only legal connect/ready transitions are transmitted
// RL3: framing bit alternates, 25 MHz divided by 32
// RL4: receiver locks onto alternating framing pattern
// RL5: two-of-three vote per received connect/ready
// RL6: stretch received connect/ready to four port clocks
// RL7: request/packet/burst have exactly four legal states
// RL8: illegal request/packet/burst combinations decode as idle
// RL9: after sequence error source restarts the connection
// RL10: sequence error never triggers link reset
// RL11: connect/ready forced low 20 us after sending
// RL12: bad frames keep last good control values
// RL13: voted bits used only while framing is locked
`ifndef OHMUX_PARAMS_SVH
`define OHMUX_PARAMS_SVH
// =====================================================
// overhead word layout
`define OH_CONNECT_LSB 0
`define OH_READY_LSB 3
`define OH_FRAMING_BIT 7
`define OH_WIDTH 8
// =====================================================
// timing
`define MCLK_MHZ 100
`define MCLK_NS 10
`define DIV25_CYC 4
`define FRAMING_DIV 32
`define HOLDOFF_US 20
`define HOLDOFF_CYC (`HOLDOFF_US * `MCLK_MHZ)
`define PH_CLK_NS 40
`define STRETCH_PERIODS 4
`define STRETCH_CYC ((`STRETCH_PERIODS * `PH_CLK_NS + `MCLK_NS - 1) / `MCLK_NS)
`define TX_MIN_FRAMES 3
`define RUN_MIN 31
`define RUN_MAX 33
// =====================================================
// apb register map
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define CTRL_ENABLE_BIT 0
`define CTRL_RESET 32'h0000_0001
`define ST_LOCKED_BIT 0
`define ST_STATE_LSB 1
`define ST_HOLDOFF_BIT 3
`define ST_SEQERR_BIT 4
`endif

// ===== inc/ohmux_pkg.sv
// types for the overhead control signal multiplexer
package ohmux_pkg;
  typedef enum logic [2:0] {
    LK_SEARCH = 3'b001,
    LK_CHECK = 3'b010,
    LK_LOCKED = 3'b100
  } lock_state_t;
  typedef enum logic [1:0] {
    RPB_IDLE = 2'h0,
    RPB_REQUEST = 2'h1,
    RPB_PACKET = 2'h2,
    RPB_BURST = 2'h3
  } rpb_state_t;
endpackage

// ===== rtl/level_shaper.sv
// holds every level change of each bit for a minimum number of ticks
`timescale 1ns/1ns
`default_nettype none
module level_shaper #(
  parameter int W = 2,
  parameter int MIN_TICKS = 3
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic tick,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  localparam int CW = $clog2(MIN_TICKS + 1);
  logic [CW-1:0] cnt_q [W];
  // =====================================================
  // per-bit shaping; a short glitch is stretched to the minimum width
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge mclk) begin
      if (rst) begin
        dout[i] <= 1'b0;
        cnt_q[i] <= '0;
      end else if (tick) begin
        if (cnt_q[i] != '0) begin
          cnt_q[i] <= cnt_q[i] - CW'(1);
        end else if (din[i] != dout[i]) begin
          dout[i] <= din[i];
          cnt_q[i] <= CW'(MIN_TICKS - 1);
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== rtl/overhead_control_signal_mux.sv
// overhead control signal multiplexer and demultiplexer with apb registers
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "ohmux_params.svh"
module overhead_control_signal_mux import ohmux_pkg::*; #(
  parameter int RUN_MIN = `RUN_MIN,
  parameter int RUN_MAX = `RUN_MAX
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic link_sending,
  input wire logic tx_frame,
  input wire logic tx_connect_pin,
  input wire logic tx_ready_pin,
  output logic [`OH_WIDTH-1:0] overhead_serial_bit_a,
  input wire logic rx_frame,
  input wire logic rx_frame_valid,
  input wire logic [`OH_WIDTH-1:0] overhead_serial_bit_b,
  input wire logic [2:0] rx_rpb_raw,
  output logic rx_request,
  output logic rx_packet,
  output logic rx_burst,
  output logic rx_connect,
  output logic rx_ready,
  output logic framing_locked
);
  // =====================================================
  // helpers
  function automatic logic maj3(input logic [2:0] v);
    return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction
  function automatic rpb_state_t rpb_decode(input logic [2:0] v);
    unique case (v)
      3'h1: return RPB_REQUEST;
      3'h3: return RPB_PACKET;
      3'h7: return RPB_BURST;
      default: return RPB_IDLE;
    endcase
  endfunction
  function automatic logic rpb_legal(input logic [2:0] v);
    return (v == 3'h0) || (rpb_decode(v) != RPB_IDLE);
  endfunction

  // =====================================================
  // apb registers
  logic [31:0] ctrl_q;
  logic seq_err_q;
  logic holdoff;
  rpb_state_t rpb_q;
  lock_state_t lk_q;
  logic sel_ctrl, sel_stat, acc, wr;
  logic [31:0] rd_d;
  assign sel_ctrl = (paddr == `REG_CTRL);
  assign sel_stat = (paddr == `REG_STATUS);
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign pready = 1'b1;
  assign pslverr = acc & ~sel_ctrl & ~sel_stat;
  always_comb begin
    rd_d = 32'h0;
    if (sel_ctrl) begin
      rd_d = ctrl_q;
    end else if (sel_stat) begin
      rd_d[`ST_LOCKED_BIT] = framing_locked;
      rd_d[`ST_STATE_LSB +: 2] = rpb_q;
      rd_d[`ST_HOLDOFF_BIT] = holdoff;
      rd_d[`ST_SEQERR_BIT] = seq_err_q;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      prdata <= 32'h0;
    end else if (psel & ~penable) begin
      prdata <= rd_d;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_q <= `CTRL_RESET;
    end else if (wr & sel_ctrl) begin
      ctrl_q <= {31'h0, pwdata[`CTRL_ENABLE_BIT]};
    end
  end

  // =====================================================
  // startup hold-off after entering the sending state
  logic [11:0] hold_cnt_q;
  always_ff @(posedge mclk) begin
    if (rst) begin
      hold_cnt_q <= 12'(`HOLDOFF_CYC);
    end else if (!link_sending) begin
      hold_cnt_q <= 12'(`HOLDOFF_CYC);
    end else if (hold_cnt_q != 12'h0) begin
      hold_cnt_q <= hold_cnt_q - 12'h1;
    end
  end
  assign holdoff = (hold_cnt_q != 12'h0);

  // =====================================================
  // transmit side
  logic [1:0] pin_s1_q, pin_s2_q, tx_shaped;
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_s1_q <= 2'h0;
      pin_s2_q <= 2'h0;
    end else begin
      pin_s1_q <= {tx_ready_pin, tx_connect_pin};
      pin_s2_q <= pin_s1_q;
    end
  end
  // a level goes out one frame after the shaper takes it and then holds for several frames
  level_shaper #(.W(2), .MIN_TICKS(`TX_MIN_FRAMES)) u_tx_shape (
    .mclk(mclk),
    .rst(rst),
    .tick(tx_frame),
    .din(pin_s2_q),
    .dout(tx_shaped)
  ); // RL2
  // framing square wave: 25 MHz tick then divide by 32
  logic [1:0] div4_q;
  logic [3:0] div16_q;
  logic framing_q;
  always_ff @(posedge mclk) begin
    if (rst) begin
      div4_q <= 2'h0;
      div16_q <= 4'h0;
      framing_q <= 1'b1;
    end else begin
      div4_q <= div4_q + 2'h1;
      if (div4_q == 2'(`DIV25_CYC - 1)) begin
        div16_q <= div16_q + 4'h1;
        if (div16_q == 4'(`FRAMING_DIV / 2 - 1)) begin
          framing_q <= ~framing_q; // RL3
        end
      end
    end
  end
  logic tx_on;
  assign tx_on = ctrl_q[`CTRL_ENABLE_BIT] & ~holdoff;
  always_ff @(posedge mclk) begin
    if (rst) begin
      overhead_serial_bit_a <= '0;
    end else if (tx_frame) begin
      overhead_serial_bit_a <= '0;
      overhead_serial_bit_a[`OH_CONNECT_LSB +: 3] <= {3{tx_shaped[0] & tx_on}}; // RL1 RL11
      overhead_serial_bit_a[`OH_READY_LSB +: 3] <= {3{tx_shaped[1] & tx_on}}; // RL1 RL11
      overhead_serial_bit_a[`OH_FRAMING_BIT] <= framing_q; // RL3
    end
  end

  // =====================================================
  // receive framing search
  logic good_frame, fb, fb_last_q, fb_edge, run_ok, run_over;
  logic [5:0] run_q;
  assign good_frame = rx_frame & rx_frame_valid;
  assign fb = overhead_serial_bit_b[`OH_FRAMING_BIT];
  assign fb_edge = good_frame & (fb != fb_last_q);
  assign run_ok = (run_q >= 6'(RUN_MIN - 1)) && (run_q <= 6'(RUN_MAX - 1));
  assign run_over = run_q > 6'(RUN_MAX - 1);
  always_ff @(posedge mclk) begin
    if (rst) begin
      fb_last_q <= 1'b0;
      run_q <= 6'h0;
    end else if (good_frame) begin
      fb_last_q <= fb;
      run_q <= fb_edge ? 6'h0 : (run_over ? run_q : run_q + 6'h1);
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      lk_q <= LK_SEARCH;
    end else if (good_frame) begin
      unique case (lk_q)
        LK_SEARCH: if (fb_edge) lk_q <= LK_CHECK; // RL4
        LK_CHECK: if (fb_edge && run_ok) lk_q <= LK_LOCKED; // RL4
        LK_LOCKED: if ((fb_edge && !run_ok) || run_over) lk_q <= LK_SEARCH; // RL4
      endcase
    end
  end
  assign framing_locked = (lk_q == LK_LOCKED);

  // =====================================================
  // receive control capture; bad frames change nothing
  logic [1:0] cr_q;
  always_ff @(posedge mclk) begin
    if (rst) begin
      rpb_q <= RPB_IDLE;
      cr_q <= 2'h0;
    end else if (good_frame) begin // RL12
      rpb_q <= rpb_decode(rx_rpb_raw); // RL7 RL8
      cr_q[0] <= maj3(overhead_serial_bit_b[`OH_CONNECT_LSB +: 3]); // RL5
      cr_q[1] <= maj3(overhead_serial_bit_b[`OH_READY_LSB +: 3]); // RL5
    end
  end
  // sticky flag only; the link keeps running, the source must redo its connect
  always_ff @(posedge mclk) begin
    if (rst) begin
      seq_err_q <= 1'b0;
    end else if (good_frame && !rpb_legal(rx_rpb_raw)) begin
      seq_err_q <= 1'b1; // RL10 RL9
    end else if (wr && sel_stat && pwdata[`ST_SEQERR_BIT]) begin
      seq_err_q <= 1'b0;
    end
  end
  assign rx_request = (rpb_q != RPB_IDLE);
  assign rx_packet = (rpb_q == RPB_PACKET) || (rpb_q == RPB_BURST);
  assign rx_burst = (rpb_q == RPB_BURST);
  logic [1:0] cr_gated;
  assign cr_gated = cr_q & {2{framing_locked & ~holdoff}}; // RL13 RL11
  level_shaper #(.W(2), .MIN_TICKS(`STRETCH_CYC)) u_rx_stretch (
    .mclk(mclk),
    .rst(rst),
    .tick(1'b1),
    .din(cr_gated),
    .dout({rx_ready, rx_connect})
  ); // RL6

  // =====================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic [4:0] con_age_q;
  always_ff @(posedge mclk) begin
    if (rst) begin
      con_age_q <= 5'h0;
    end else if (rx_connect != $past(rx_connect)) begin
      con_age_q <= 5'h1;
    end else if (con_age_q != 5'h1f) begin
      con_age_q <= con_age_q + 5'h1;
    end
  end
  a_tx_triplicate: assert property ( // RL1
    overhead_serial_bit_a[2:0] inside {3'h0, 3'h7} && overhead_serial_bit_a[5:3] inside {3'h0, 3'h7})
    else $error("tx overhead copies differ");
  a_tx_holdoff_zero: assert property ( // RL11
    $past(tx_frame) && $past(holdoff) |-> overhead_serial_bit_a[5:0] == 6'h0)
    else $error("tx connect/ready sent during hold-off");
  a_framing_period: assert property ( // RL3
    $changed(framing_q) |=> !$changed(framing_q) [*8])
    else $error("framing bit toggles too fast");
  a_rx_vote: assert property ( // RL5
    good_frame && overhead_serial_bit_b[2:0] == 3'h6 |=> cr_q[0])
    else $error("connect vote wrong");
  a_rx_stretch_min: assert property ( // RL6
    $changed(rx_connect) |-> con_age_q >= 5'(`STRETCH_CYC))
    else $error("connect pulse too short");
  a_rpb_illegal_idle: assert property ( // RL8
    good_frame && rx_rpb_raw == 3'h5 |=> rpb_q == RPB_IDLE)
    else $error("illegal request/packet/burst not idle");
  a_rpb_legal_set: assert property ( // RL7
    rx_burst |-> rx_packet && rx_request)
    else $error("illegal control state driven");
  a_bad_frame_hold: assert property ( // RL12
    rx_frame && !rx_frame_valid |=> $stable(rpb_q) && $stable(cr_q))
    else $error("bad frame changed controls");
  a_unlocked_quiet: assert property ( // RL13
    !framing_locked [*2] |-> !cr_gated[0] && !cr_gated[1])
    else $error("voted bits used without lock");
  a_seq_err_sticky: assert property ( // RL10
    good_frame && !rpb_legal(rx_rpb_raw) |=> seq_err_q)
    else $error("sequence error not flagged");
  c_lock_reached: cover property (lk_q == LK_CHECK ##[1:200] framing_locked);
  c_connect_out: cover property ($rose(rx_connect));
  c_seq_error: cover property ($rose(seq_err_q));
endmodule
`default_nettype wire

// ===== sim/serdes_model.sv
// far-side model: frame timing, framing pattern and received overhead words
`timescale 1ns/1ns
`default_nettype none
module serdes_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [2:0] conn3,
  input wire logic [2:0] rdy3,
  input wire logic good,
  input wire logic [3:0] half,
  output logic tx_frame,
  output logic rx_frame,
  output logic rx_frame_valid,
  output logic [7:0] word
);
  logic [1:0] ph_q;
  logic [3:0] run_q;
  logic fbit_q;
  logic [7:0] w;
  // ====================
  // frame timing: one transmit and one receive frame every four clocks
  always_ff @(posedge mclk) begin
    if (rst) begin
      ph_q <= 2'h0;
    end else begin
      ph_q <= ph_q + 2'h1;
    end
  end
  assign tx_frame = (ph_q == 2'h3);
  assign rx_frame = (ph_q == 2'h1);
  assign rx_frame_valid = good;
  // ====================
  // framing bit flips after every half valid frames; a small half breaks the lock
  always_ff @(posedge mclk) begin
    if (rst) begin
      run_q <= 4'h0;
      fbit_q <= 1'b1;
    end else if (rx_frame && good) begin
      if (run_q >= half - 4'h1) begin
        run_q <= 4'h0;
        fbit_q <= ~fbit_q;
      end else begin
        run_q <= run_q + 4'h1;
      end
    end
  end
  assign w = {fbit_q, 1'b0, rdy3, conn3};
  // a bad frame carries scrambled bits, never a stale copy
  assign word = good ? w : ~w;
endmodule
`default_nettype wire

// ===== sim/tb_overhead_control_signal_mux.sv
// self-checking bench for the overhead control signal multiplexer
`timescale 1ns/1ns
`default_nettype none
`include "ohmux_params.svh"
module tb_overhead_control_signal_mux;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, er, good, link_sending;
  logic txc, txr, tx_frame, rx_frame, rx_frame_valid, rq, pk, bu, rc, rr, lk;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] oha, ohb;
  logic [2:0] raw, conn3, rdy3;
  logic [3:0] half;
  int error_cnt, checks;
  // ====================
  // short framing runs keep lock time small
  overhead_control_signal_mux #(.RUN_MIN(3), .RUN_MAX(5)) DUT (.mclk(mclk), .rst(rst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_sending(link_sending),
    .tx_frame(tx_frame), .tx_connect_pin(txc), .tx_ready_pin(txr),
    .overhead_serial_bit_a(oha), .rx_frame(rx_frame), .rx_frame_valid(rx_frame_valid),
    .overhead_serial_bit_b(ohb), .rx_rpb_raw(raw), .rx_request(rq), .rx_packet(pk),
    .rx_burst(bu), .rx_connect(rc), .rx_ready(rr), .framing_locked(lk));
  serdes_model far (.mclk(mclk), .rst(rst), .conn3(conn3), .rdy3(rdy3), .good(good),
    .half(half), .tx_frame(tx_frame), .rx_frame(rx_frame),
    .rx_frame_valid(rx_frame_valid), .word(ohb));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ====================
  // helpers
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      error_cnt++;
      $display("ERROR wait expected done seen timeout");
      give_verdict();
    end
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic fr(input int n);
    repeat (4 * n) @(posedge mclk);
  endtask
  function automatic logic maj(input logic [2:0] p);
    return (p[0] & p[1]) | (p[0] & p[2]) | (p[1] & p[2]);
  endfunction
  // request held until pready seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    tmo(n, 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  // ====================
  // scenarios
  task automatic t_regs();
    apb(1'b0, `REG_CTRL, 32'h0);
    chk("ctrl", `CTRL_RESET, rd);
    apb(1'b0, `REG_STATUS, 32'h0);
    chk("locked", 32'h0, {31'h0, rd[0]});
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    $display("regs done");
  endtask
  task automatic t_hold();
    int n;
    n = 0;
    link_sending <= 1'b1;
    while (lk !== 1'b1 && n < 300) begin
      @(posedge mclk);
      n++;
    end
    tmo(n, 300);
    repeat (1850) @(posedge mclk);
    chk("rx held", 32'h0, {30'h0, rr, rc});
    chk("tx held", 32'h0, {26'h0, oha[5:0]});
    apb(1'b0, `REG_STATUS, 32'h0);
    chk("holdoff", 32'h1, {31'h0, rd[3]});
    repeat (300) @(posedge mclk);
    chk("rx free", 32'h3, {30'h0, rr, rc});
    chk("tx word", 32'h3f, {26'h0, oha[5:0]});
    $display("holdoff done");
  endtask
  task automatic t_tx();
    int zr, runs, run;
    logic [7:0] last;
    zr = 0;
    runs = 0;
    run = 0;
    last = oha;
    txc <= 1'b0;
    for (int i = 0; i < 80; i++) begin
      fr(1);
      // a one-frame low pulse must still leave as a full minimum-width low
      if (i == 0) txc <= 1'b1;
      if (oha[2:0] == 3'h0) zr++;
      chk("triplet", 32'h1, {31'h0, oha[2:0] == 3'h0 || oha[2:0] == 3'h7});
      if (oha[7] !== last[7]) begin
        if (runs > 0) chk("framing run", 32'd16, run);
        runs++;
        run = 0;
      end
      run++;
      last = oha;
    end
    chk("short low", `TX_MIN_FRAMES, zr);
    chk("framing runs", 32'h1, {31'h0, runs > 2});
    $display("tx done");
  endtask
  task automatic t_vote();
    logic [2:0] pat [6] = '{3'h6, 3'h0, 3'h3, 3'h4, 3'h5, 3'h1};
    for (int i = 0; i < 6; i++) begin
      conn3 <= pat[i];
      rdy3 <= ~pat[i];
      fr(8);
      chk("vote connect", {31'h0, maj(pat[i])}, {31'h0, rc});
      chk("vote ready", {31'h0, maj(~pat[i])}, {31'h0, rr});
    end
    $display("vote done");
  endtask
  task automatic t_stretch();
    int n, h;
    n = 0;
    h = 0;
    conn3 <= 3'h7;
    fr(1);
    conn3 <= 3'h0;
    while (rc !== 1'b1 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    tmo(n, 20);
    while (rc === 1'b1 && h < 100) begin
      @(posedge mclk);
      h++;
    end
    chk("stretch", `STRETCH_CYC, h);
    $display("stretch done");
  endtask
  task automatic t_rpb();
    // a broken sequence returns to idle before a fresh request
    logic [2:0] sq [13] = '{0, 1, 3, 7, 3, 1, 2, 0, 1, 4, 5, 6, 0};
    logic [2:0] e;
    for (int i = 0; i < 13; i++) begin
      raw <= sq[i];
      fr(2);
      e = (sq[i] == 0 || sq[i] == 1 || sq[i] == 3 || sq[i] == 7) ? sq[i] : 3'h0;
      chk("rpb", {29'h0, e}, {29'h0, bu, pk, rq});
      chk("link kept", 32'h1, {31'h0, lk});
    end
    apb(1'b0, `REG_STATUS, 32'h0);
    chk("seq err", 32'h1, {31'h0, rd[4]});
    apb(1'b1, `REG_STATUS, 32'h10);
    apb(1'b0, `REG_STATUS, 32'h0);
    chk("seq clear", 32'h0, {31'h0, rd[4]});
    $display("rpb done");
  endtask
  task automatic t_bad();
    raw <= 3'h7;
    conn3 <= 3'h7;
    rdy3 <= 3'h7;
    fr(8);
    good <= 1'b0;
    raw <= 3'h0;
    conn3 <= 3'h0;
    rdy3 <= 3'h0;
    fr(12);
    chk("bad hold", 32'h1f, {27'h0, rr, rc, bu, pk, rq});
    chk("bad lock", 32'h1, {31'h0, lk});
    good <= 1'b1;
    $display("bad frame done");
  endtask
  task automatic t_unlock();
    half <= 4'h1;
    conn3 <= 3'h7;
    fr(40);
    chk("unlocked", 32'h0, {31'h0, lk});
    chk("rx off", 32'h0, {31'h0, rc});
    $display("unlock done");
  endtask
  // ====================
  // main sequence
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    link_sending = 1'b0;
    txc = 1'b1;
    txr = 1'b1;
    good = 1'b1;
    raw = 3'h0;
    conn3 = 3'h7;
    rdy3 = 3'h7;
    half = 4'h4;
    error_cnt = 0;
    checks = 0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_hold();
    t_tx();
    t_vote();
    t_stretch();
    t_rpb();
    t_bad();
    t_unlock();
    give_verdict();
  end
endmodule
`default_nettype wire
